// ===== inc/bsfu_pkg.sv
// Purpose: Shared constants and types for the bit shift and flag unit.
// Assumes: One core clock; operands arrive from the decoder and register file.
// Notes:   Status bit positions follow the core status register layout.
package bsfu_pkg;

   // ----------------------------------------------------------------
   // Widths and status register layout
   // ----------------------------------------------------------------
   localparam int DATA_W = 8;
   localparam int IDX_W = 5;
   localparam int SEL_W = 3;
   localparam int ST_C = 0;
   localparam int ST_Z = 1;
   localparam int ST_N = 2;
   localparam int ST_V = 3;
   localparam int ST_S = 4;
   localparam int ST_H = 5;
   localparam int ST_T = 6;
   localparam int ST_I = 7;
   localparam logic [DATA_W-1:0] STATUS_RST = 8'h00;
   localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
   localparam logic [IDX_W-1:0] IDX_RST = 5'h00;
   localparam int OP_LATENCY = 1;

   // ----------------------------------------------------------------
   // Operation codes
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      BSFU_ROTATE_LEFT_CARRY = 4'b0000,
      BSFU_ROTATE_RIGHT_CARRY = 4'b0001,
      BSFU_BIT_TO_TRANSFER_FLAG = 4'b0010,
      BSFU_TRANSFER_FLAG_TO_BIT = 4'b0011,
      BSFU_SET_OVERFLOW = 4'b0100,
      BSFU_CLEAR_OVERFLOW = 4'b0101,
      BSFU_SET_SIGN_FLAG = 4'b0110,
      BSFU_CLEAR_SIGN_FLAG = 4'b0111,
      BSFU_SET_HALF_CARRY = 4'b1000,
      BSFU_CLEAR_HALF_CARRY = 4'b1001
   } bsfu_op_t;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      bsfu_op_t op;
      logic [IDX_W-1:0] idx;
      logic [DATA_W-1:0] operand;
      logic [SEL_W-1:0] bit_sel;
   } bsfu_req_t;

   typedef struct packed {
      logic valid;
      logic [IDX_W-1:0] idx;
      logic [DATA_W-1:0] data;
   } bsfu_wb_t;

endpackage : bsfu_pkg

// ===== verilog/bsfu_bit_path.sv
// Purpose: Combinational rotate and bit-insert datapath.
// Assumes: Caller registers the outputs.
// Notes:   Carry out is meaningful only for the two rotate operations.
`timescale 1ns/100ps
module bsfu_bit_path (
   input wire bsfu_pkg::bsfu_op_t op,
   input wire logic [bsfu_pkg::DATA_W-1:0] operand,
   input wire logic [bsfu_pkg::SEL_W-1:0] bit_sel,
   input wire logic carry_in,
   input wire logic t_flag,
   output logic [bsfu_pkg::DATA_W-1:0] result,
   output logic carry_out
);

   logic [bsfu_pkg::DATA_W-1:0] inserted;

   // ----------------------------------------------------------------
   // Transfer flag insert, one mux per bit
   // ----------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < bsfu_pkg::DATA_W; gi++) begin : g_ins
         localparam int unsigned BIT_POS = gi;
         assign inserted[gi] = (bit_sel == BIT_POS[bsfu_pkg::SEL_W-1:0])
            ? t_flag : operand[gi];
      end
   endgenerate

   always_comb begin
      result = operand;
      carry_out = carry_in;
      unique case (op)
         bsfu_pkg::BSFU_ROTATE_LEFT_CARRY: begin
            result = {operand[bsfu_pkg::DATA_W-2:0], carry_in};
            carry_out = operand[bsfu_pkg::DATA_W-1];
         end
         bsfu_pkg::BSFU_ROTATE_RIGHT_CARRY: begin
            result = {carry_in, operand[bsfu_pkg::DATA_W-1:1]};
            carry_out = operand[0];
         end
         bsfu_pkg::BSFU_TRANSFER_FLAG_TO_BIT: begin
            result = inserted;
         end
         default: begin
            result = operand;
         end
      endcase
   end

endmodule : bsfu_bit_path

// ===== verilog/bsfu_unit.sv
// Purpose: Rotate-through-carry, bit transfer and flag set/clear execution unit.
// Assumes: Decoder presents one request per cycle with the operand already read.
// Notes:   Results and status appear one clock after the request is taken.
//
// Functional notes
// - Rotate left via carry; update Z,C,N,V.
// - Rotate right via carry; update Z,C,N,V.
// - Bit store copies selected bit into T.
// - Bit load writes T into selected bit.
// - Set/clear overflow flag only, one clock.
// - Set/clear sign flag only, one clock.
// - Set/clear half-carry flag only, one clock.
`timescale 1ns/100ps
module bsfu_unit (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic req_valid,
   input wire bsfu_pkg::bsfu_req_t req,
   output logic [bsfu_pkg::DATA_W-1:0] status_q,
   output bsfu_pkg::bsfu_wb_t wb_q,
   output logic done_q
);

   // ----------------------------------------------------------------
   // Datapath
   // ----------------------------------------------------------------
   logic [bsfu_pkg::DATA_W-1:0] path_result;
   logic path_carry;
   logic [bsfu_pkg::DATA_W-1:0] status_d;
   bsfu_pkg::bsfu_wb_t wb_d;
   logic done_d;
   logic res_n;
   logic res_z;

   // Carry and transfer flag feed the datapath straight from the status register.
   bsfu_bit_path u_path (
      .op(req.op),
      .operand(req.operand),
      .bit_sel(req.bit_sel),
      .carry_in(status_q[bsfu_pkg::ST_C]),
      .t_flag(status_q[bsfu_pkg::ST_T]),
      .result(path_result),
      .carry_out(path_carry)
   );

   assign res_n = path_result[bsfu_pkg::DATA_W-1];
   assign res_z = (path_result == bsfu_pkg::DATA_ZERO);

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   // Codes outside the enum are dropped silently so a decoder glitch
   // never corrupts the status register.
   always_comb begin
      status_d = status_q;
      wb_d = '0;
      done_d = 1'b0;
      if (req_valid) begin
         done_d = 1'b1;
         unique case (req.op)
            bsfu_pkg::BSFU_ROTATE_LEFT_CARRY,
            bsfu_pkg::BSFU_ROTATE_RIGHT_CARRY: begin
               status_d[bsfu_pkg::ST_C] = path_carry;
               status_d[bsfu_pkg::ST_Z] = res_z;
               status_d[bsfu_pkg::ST_N] = res_n;
               // Overflow is the new sign xor the new carry, so a rotate used as
               // a signed doubling reports the sign change it caused.
               status_d[bsfu_pkg::ST_V] = res_n ^ path_carry;
               wb_d.valid = 1'b1;
               wb_d.idx = req.idx;
               wb_d.data = path_result;
            end
            bsfu_pkg::BSFU_BIT_TO_TRANSFER_FLAG: begin
               status_d[bsfu_pkg::ST_T] = req.operand[req.bit_sel];
            end
            bsfu_pkg::BSFU_TRANSFER_FLAG_TO_BIT: begin
               wb_d.valid = 1'b1;
               wb_d.idx = req.idx;
               wb_d.data = path_result;
            end
            bsfu_pkg::BSFU_SET_OVERFLOW: status_d[bsfu_pkg::ST_V] = 1'b1;
            bsfu_pkg::BSFU_CLEAR_OVERFLOW: status_d[bsfu_pkg::ST_V] = 1'b0;
            bsfu_pkg::BSFU_SET_SIGN_FLAG: status_d[bsfu_pkg::ST_S] = 1'b1;
            bsfu_pkg::BSFU_CLEAR_SIGN_FLAG: status_d[bsfu_pkg::ST_S] = 1'b0;
            bsfu_pkg::BSFU_SET_HALF_CARRY: status_d[bsfu_pkg::ST_H] = 1'b1;
            bsfu_pkg::BSFU_CLEAR_HALF_CARRY: status_d[bsfu_pkg::ST_H] = 1'b0;
            default: begin
               done_d = 1'b0;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   // Status lives here rather than in the decoder so that each operation sees
   // the flags left by the one before it, even back to back.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         status_q <= bsfu_pkg::STATUS_RST;
         wb_q <= '0;
         done_q <= 1'b0;
      end else begin
         status_q <= status_d;
         wb_q <= wb_d;
         done_q <= done_d;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   // Every check below looks one edge after the cycle it tests, which is
   // the single-cycle latency of the unit.
   sequence take_s(bsfu_pkg::bsfu_op_t o);
      req_valid && req.op == o;
   endsequence

   rol_result_a: assert property (
      take_s(bsfu_pkg::BSFU_ROTATE_LEFT_CARRY) |=>
         wb_q.data == {$past(req.operand[6:0]), $past(status_q[bsfu_pkg::ST_C])}
         && status_q[bsfu_pkg::ST_C] == $past(req.operand[7]))
      else $error("Rotate left result or carry wrong.");

   ror_result_a: assert property (
      take_s(bsfu_pkg::BSFU_ROTATE_RIGHT_CARRY) |=>
         wb_q.data == {$past(status_q[bsfu_pkg::ST_C]), $past(req.operand[7:1])}
         && status_q[bsfu_pkg::ST_C] == $past(req.operand[0]))
      else $error("Rotate right result or carry wrong.");

   rot_flags_a: assert property (
      (take_s(bsfu_pkg::BSFU_ROTATE_LEFT_CARRY) or take_s(bsfu_pkg::BSFU_ROTATE_RIGHT_CARRY))
      |=> status_q[bsfu_pkg::ST_Z] == (wb_q.data == bsfu_pkg::DATA_ZERO)
         && status_q[bsfu_pkg::ST_N] == wb_q.data[7]
         && status_q[bsfu_pkg::ST_V] == (wb_q.data[7] ^ status_q[bsfu_pkg::ST_C])
         && status_q[7:4] == $past(status_q[7:4]))
      else $error("Rotate flags wrong.");

   bit_store_a: assert property (
      take_s(bsfu_pkg::BSFU_BIT_TO_TRANSFER_FLAG) |=>
         status_q[bsfu_pkg::ST_T] == $past(req.operand[req.bit_sel])
         && (status_q ^ $past(status_q)) inside {8'h00, 8'h40} && !wb_q.valid)
      else $error("Bit store wrong.");

   bit_load_a: assert property (
      take_s(bsfu_pkg::BSFU_TRANSFER_FLAG_TO_BIT) |=>
         wb_q.valid && wb_q.data[$past(req.bit_sel)] == $past(status_q[bsfu_pkg::ST_T])
         && status_q == $past(status_q))
      else $error("Bit load wrong.");

   overflow_op_a: assert property (
      take_s(bsfu_pkg::BSFU_SET_OVERFLOW) or take_s(bsfu_pkg::BSFU_CLEAR_OVERFLOW) |=>
         status_q[bsfu_pkg::ST_V] == ($past(req.op) == bsfu_pkg::BSFU_SET_OVERFLOW)
         && (status_q ^ $past(status_q)) inside {8'h00, 8'h08})
      else $error("Overflow set/clear wrong.");

   sign_op_a: assert property (
      take_s(bsfu_pkg::BSFU_SET_SIGN_FLAG) or take_s(bsfu_pkg::BSFU_CLEAR_SIGN_FLAG) |=>
         status_q[bsfu_pkg::ST_S] == ($past(req.op) == bsfu_pkg::BSFU_SET_SIGN_FLAG)
         && (status_q ^ $past(status_q)) inside {8'h00, 8'h10})
      else $error("Sign set/clear wrong.");

   half_op_a: assert property (
      take_s(bsfu_pkg::BSFU_SET_HALF_CARRY) or take_s(bsfu_pkg::BSFU_CLEAR_HALF_CARRY) |=>
         status_q[bsfu_pkg::ST_H] == ($past(req.op) == bsfu_pkg::BSFU_SET_HALF_CARRY)
         && (status_q ^ $past(status_q)) inside {8'h00, 8'h20})
      else $error("Half-carry set/clear wrong.");

   wb_target_a: assert property (
      req_valid && req.op inside {bsfu_pkg::BSFU_ROTATE_LEFT_CARRY,
         bsfu_pkg::BSFU_ROTATE_RIGHT_CARRY, bsfu_pkg::BSFU_TRANSFER_FLAG_TO_BIT}
      |=> wb_q.valid && wb_q.idx == $past(req.idx))
      else $error("Write-back target wrong.");

   no_wb_flag_a: assert property (
      !(req_valid && req.op inside {bsfu_pkg::BSFU_ROTATE_LEFT_CARRY,
         bsfu_pkg::BSFU_ROTATE_RIGHT_CARRY, bsfu_pkg::BSFU_TRANSFER_FLAG_TO_BIT})
      |=> !wb_q.valid)
      else $error("Unexpected write-back.");

   bld_keep_a: assert property (
      take_s(bsfu_pkg::BSFU_TRANSFER_FLAG_TO_BIT) |=>
         ((wb_q.data ^ $past(req.operand)) & ~(8'h01 << $past(req.bit_sel))) == 8'h00)
      else $error("Bit load changed another bit.");

   // A refused code must look like an idle cycle on every output, so a
   // corrupted decode never leaves a half-finished instruction behind.
   refused_op_a: assert property (
      req_valid && req.op > bsfu_pkg::BSFU_CLEAR_HALF_CARRY |=>
         !done_q && !wb_q.valid && status_q == $past(status_q))
      else $error("Refused code changed state.");

   done_pulse_a: assert property (
      req_valid && req.op <= bsfu_pkg::BSFU_CLEAR_HALF_CARRY |=> done_q)
      else $error("Done pulse missing.");

   idle_done_a: assert property (
      !req_valid |=> !done_q)
      else $error("Done pulse while idle.");

   // The interrupt enable bit belongs to another unit; nothing here may
   // disturb it, whatever sequence of operations arrives.
   ie_keep_a: assert property (
      status_q[bsfu_pkg::ST_I] == $past(status_q[bsfu_pkg::ST_I]))
      else $error("Interrupt enable bit changed.");

   rol_carry_cv: cover property (take_s(bsfu_pkg::BSFU_ROTATE_LEFT_CARRY)
      ##1 take_s(bsfu_pkg::BSFU_ROTATE_LEFT_CARRY));
   bst_bld_cv: cover property (take_s(bsfu_pkg::BSFU_BIT_TO_TRANSFER_FLAG)
      ##1 take_s(bsfu_pkg::BSFU_TRANSFER_FLAG_TO_BIT));
   flag_op_cv: cover property (take_s(bsfu_pkg::BSFU_SET_OVERFLOW)
      ##1 take_s(bsfu_pkg::BSFU_CLEAR_SIGN_FLAG));
   ror_carry_cv: cover property (take_s(bsfu_pkg::BSFU_ROTATE_RIGHT_CARRY)
      ##1 take_s(bsfu_pkg::BSFU_ROTATE_RIGHT_CARRY));
   refused_cv: cover property (req_valid
      && req.op > bsfu_pkg::BSFU_CLEAR_HALF_CARRY);

endmodule : bsfu_unit

// ===== verif/bsfu_regfile_model.sv
// Purpose: Decoder and register file model that feeds the bit shift and flag unit.
// Assumes: Commands come from the bench; write-backs come from the unit.
// Notes:   Register contents start from a fixed pattern at reset.
`timescale 1ns/100ps
module bsfu_regfile_model (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic cmd_valid,
   input wire bsfu_pkg::bsfu_op_t cmd_op,
   input wire logic [bsfu_pkg::IDX_W-1:0] cmd_idx,
   input wire logic [bsfu_pkg::SEL_W-1:0] cmd_sel,
   input wire bsfu_pkg::bsfu_wb_t wb_q,
   output logic req_valid,
   output bsfu_pkg::bsfu_req_t req
);
   logic [bsfu_pkg::DATA_W-1:0] regs_q [32];
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < 32; i++) begin
            regs_q[i] <= 8'h81 + 8'(i) * 8'h13;
         end
      end else if (wb_q.valid) begin
         regs_q[wb_q.idx] <= wb_q.data;
      end
   end
   // Forwarding keeps back-to-back ops on one register from reading a stale value.
   always_comb begin
      req_valid = cmd_valid;
      req.op = cmd_op;
      req.idx = cmd_idx;
      req.bit_sel = cmd_sel;
      req.operand = (wb_q.valid && wb_q.idx == cmd_idx) ? wb_q.data : regs_q[cmd_idx];
   end
endmodule : bsfu_regfile_model

// ===== verif/tb_bit_shift_flag_unit.sv
// Purpose: Self-checking bench for the bit shift and flag unit.
// Assumes: Inputs change at the falling edge; results are due one clock later.
// Notes:   A shadow copy of status and registers gives the expected values.
`timescale 1ns/100ps
module tb_bit_shift_flag_unit;
   logic clk_sys;
   logic rst_n;
   logic cmd_valid;
   bsfu_pkg::bsfu_op_t cmd_op;
   logic [bsfu_pkg::IDX_W-1:0] cmd_idx;
   logic [bsfu_pkg::SEL_W-1:0] cmd_sel;
   logic req_valid;
   bsfu_pkg::bsfu_req_t req;
   logic [7:0] status_q;
   bsfu_pkg::bsfu_wb_t wb_q;
   logic done_q;
   logic [7:0] exp_st;
   logic [7:0] exp_r [32];
   int mismatches;
   int checks;
   bsfu_regfile_model pm_u (.clk_sys(clk_sys), .rst_n(rst_n), .cmd_valid(cmd_valid),
      .cmd_op(cmd_op), .cmd_idx(cmd_idx), .cmd_sel(cmd_sel), .wb_q(wb_q),
      .req_valid(req_valid), .req(req));
   bsfu_unit dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .req_valid(req_valid), .req(req),
      .status_q(status_q), .wb_q(wb_q), .done_q(done_q));
   // ----------------------------------------------------------------
   // Checking tasks
   // ----------------------------------------------------------------
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string msg);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: %s got %h expected %h", $time, msg, got, exp);
      end
   endtask : chk8
   task automatic chk1(input logic got, input logic exp, input string msg);
      chk8({7'h00, got}, {7'h00, exp}, msg);
   endtask : chk1
   task automatic final_report;
      $display("Checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : final_report
   task automatic mirror_reset;
      exp_st = bsfu_pkg::STATUS_RST;
      for (int i = 0; i < 32; i++) begin
         exp_r[i] = 8'h81 + 8'(i) * 8'h13;
      end
   endtask : mirror_reset
   // Issues one request at a falling edge and checks the answer at the next falling edge.
   task automatic exec(input bsfu_pkg::bsfu_op_t op, input logic [4:0] idx,
                       input logic [2:0] sel);
      logic [7:0] v;
      logic [7:0] r;
      logic wb;
      logic ok;
      logic rot;
      v = exp_r[idx];
      r = v;
      wb = 1'b0;
      ok = 1'b1;
      rot = 1'b0;
      cmd_valid = 1'b1;
      cmd_op = op;
      cmd_idx = idx;
      cmd_sel = sel;
      if (op == bsfu_pkg::BSFU_ROTATE_LEFT_CARRY) begin
         r = {v[6:0], exp_st[bsfu_pkg::ST_C]};
         exp_st[bsfu_pkg::ST_C] = v[7];
         rot = 1'b1;
      end else if (op == bsfu_pkg::BSFU_ROTATE_RIGHT_CARRY) begin
         r = {exp_st[bsfu_pkg::ST_C], v[7:1]};
         exp_st[bsfu_pkg::ST_C] = v[0];
         rot = 1'b1;
      end else if (op == bsfu_pkg::BSFU_BIT_TO_TRANSFER_FLAG) begin
         exp_st[bsfu_pkg::ST_T] = v[sel];
      end else if (op == bsfu_pkg::BSFU_TRANSFER_FLAG_TO_BIT) begin
         r[sel] = exp_st[bsfu_pkg::ST_T];
         wb = 1'b1;
      end else if (op < 4'hA) begin
         exp_st[(op < 4'h6) ? bsfu_pkg::ST_V : (op < 4'h8) ? bsfu_pkg::ST_S
            : bsfu_pkg::ST_H] = ~op[0];
      end else begin
         ok = 1'b0;
      end
      if (rot) begin
         wb = 1'b1;
         exp_st[bsfu_pkg::ST_Z] = (r == 8'h00);
         exp_st[bsfu_pkg::ST_N] = r[7];
         exp_st[bsfu_pkg::ST_V] = r[7] ^ exp_st[bsfu_pkg::ST_C];
      end
      @(posedge clk_sys);
      @(negedge clk_sys);
      chk1(done_q, ok, "done");
      chk8(status_q, exp_st, "status");
      chk1(wb_q.valid, wb, "write-back valid");
      if (wb) begin
         chk8({3'h0, wb_q.idx}, {3'h0, idx}, "write-back index");
         chk8(wb_q.data, r, "write-back data");
         exp_r[idx] = r;
      end
   endtask : exec
   task automatic idle;
      cmd_valid = 1'b0;
      @(posedge clk_sys);
      @(negedge clk_sys);
      chk1(done_q, 1'b0, "done while idle");
      chk1(wb_q.valid, 1'b0, "write-back while idle");
   endtask : idle
   // ----------------------------------------------------------------
   // Clock, watchdog and test sequence
   // ----------------------------------------------------------------
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   initial begin
      #40000;
      mismatches++;
      $display("Error at %0t: watchdog expired", $time);
      final_report();
   end
   initial begin
      rst_n = 1'b0;
      cmd_valid = 1'b0;
      cmd_op = bsfu_pkg::BSFU_ROTATE_LEFT_CARRY;
      cmd_idx = 5'h00;
      cmd_sel = 3'h0;
      mismatches = 0;
      checks = 0;
      mirror_reset();
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      rst_n = 1'b1;
      chk8(status_q, bsfu_pkg::STATUS_RST, "status after reset");
      exec(bsfu_pkg::BSFU_ROTATE_LEFT_CARRY, 5'h03, 3'h0);
      exec(bsfu_pkg::BSFU_ROTATE_LEFT_CARRY, 5'h03, 3'h0);
      exec(bsfu_pkg::BSFU_ROTATE_RIGHT_CARRY, 5'h05, 3'h0);
      exec(bsfu_pkg::BSFU_ROTATE_RIGHT_CARRY, 5'h05, 3'h0);
      for (int s = 0; s < 8; s++) exec(bsfu_pkg::BSFU_BIT_TO_TRANSFER_FLAG, 5'h07, 3'(s));
      for (int s = 0; s < 8; s++) exec(bsfu_pkg::BSFU_TRANSFER_FLAG_TO_BIT, 5'h09, 3'(s));
      exec(bsfu_pkg::BSFU_BIT_TO_TRANSFER_FLAG, 5'h03, 3'h0);
      exec(bsfu_pkg::BSFU_TRANSFER_FLAG_TO_BIT, 5'h0B, 3'h7);
      for (int j = 0; j < 9; j++) exec(bsfu_pkg::BSFU_ROTATE_LEFT_CARRY, 5'h0B, 3'h0);
      for (int j = 0; j < 12; j++) begin
         exec(bsfu_pkg::bsfu_op_t'(4'h4 + 4'((j < 6) ? j : ((j - 6) ^ 1))), 5'h00, 3'h0);
      end
      for (int k = 10; k < 16; k++) exec(bsfu_pkg::bsfu_op_t'(4'(k)), 5'h02, 3'h0);
      idle();
      exec(bsfu_pkg::BSFU_SET_HALF_CARRY, 5'h00, 3'h0);
      exec(bsfu_pkg::BSFU_SET_SIGN_FLAG, 5'h00, 3'h0);
      rst_n = 1'b0;
      #1;
      chk8(status_q, bsfu_pkg::STATUS_RST, "status in mid-run reset");
      chk1(done_q, 1'b0, "done in mid-run reset");
      chk1(wb_q.valid, 1'b0, "write-back in mid-run reset");
      mirror_reset();
      @(negedge clk_sys);
      rst_n = 1'b1;
      exec(bsfu_pkg::BSFU_ROTATE_RIGHT_CARRY, 5'h03, 3'h0);
      idle();
      final_report();
   end
endmodule : tb_bit_shift_flag_unit
